// ===== ipr_consts.vh
/*
  Constants for the priority register slice: offsets, field positions,
  reset values and bus answer codes.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef IPR_CONSTS_VH
`define IPR_CONSTS_VH

`define IPR_ADDR_W 4
`define IPR_OFF_SPI 4'h0
`define IPR_OFF_CAP 4'h4
`define IPR_FIELD_W 3
`define IPR_FIELD_RESET 3'h4
`define IPR_SPI_EVT_LSB 4
`define IPR_SPI_FLT_LSB 0
`define IPR_CAP5_LSB 12
`define IPR_CAP4_LSB 8
`define IPR_CAP3_LSB 4
`define IPR_NUM_FIELDS 5
`define IPR_RESP_OKAY 2'h0
`define IPR_RESP_SLVERR 2'h2

`endif

// ===== ipr_field.v
/*
  One 3-bit priority field with its byte-lane write path.
  Assumes the parent decodes the address and selects the lane.
*/
`timescale 1ns/1ns
module ipr_field (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // Write path.
  input wire wr_en,
  input wire [2:0] wr_data,
  // Field value.
  output reg [2:0] value
);
`include "ipr_consts.vh"

  always @(posedge clk) begin
    if (srst) begin
      value <= `IPR_FIELD_RESET;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end

endmodule // ipr_field

// ===== ipr_regs.v
/*
  AXI4-Lite slave holding two priority registers with five 3-bit
  fields that feed the arbitration logic.
  Assumes a single-clock master following AXI4-Lite rules.
*/
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module ipr_regs (
  // Clock and reset.
  input wire CLK_SYS,
  input wire SRST,
  // Write address channel.
  input wire [31:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  // Write data channel.
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  // Write response channel.
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // Read address channel.
  input wire [31:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  // Read data channel.
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Priority fields to arbitration.
  output reg [2:0] SERIAL_PORT_EVENT_PRIORITY,
  output reg [2:0] SERIAL_PORT_FAULT_PRIORITY,
  output reg [2:0] CAPTURE_CH5_PRIORITY,
  output reg [2:0] CAPTURE_CH4_PRIORITY,
  output reg [2:0] CAPTURE_CH3_PRIORITY
);
`include "ipr_consts.vh"

  reg aw_held;
  reg w_held;
  reg [31:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire have_aw;
  wire have_w;
  wire [31:0] cur_awaddr;
  wire [31:0] cur_wdata;
  wire [3:0] cur_wstrb;
  wire do_write;
  wire hit_spi;
  wire hit_cap;
  wire [14:0] field_val;
  wire [15:0] spi_word;
  wire [15:0] cap_word;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  // Each channel is captured once and held until the other one arrives and the write is done.
  assign have_aw = aw_held | (S_AXI_AWVALID & S_AXI_AWREADY);
  assign have_w = w_held | (S_AXI_WVALID & S_AXI_WREADY);
  assign cur_awaddr = aw_held ? aw_addr : S_AXI_AWADDR;
  assign cur_wdata = w_held ? w_data : S_AXI_WDATA;
  assign cur_wstrb = w_held ? w_strb : S_AXI_WSTRB;
  assign do_write = have_aw & have_w & ~S_AXI_BVALID;
  assign hit_spi = (cur_awaddr[31:2] == {26'h0, `IPR_OFF_SPI >> 2});
  assign hit_cap = (cur_awaddr[31:2] == {26'h0, `IPR_OFF_CAP >> 2});

  // Field order from the top: event, fault, ch5, ch4, ch3.
  genvar gi;
  generate
    for (gi = 0; gi < `IPR_NUM_FIELDS; gi = gi + 1) begin : g_field
      localparam integer LSB =
        (gi == 4) ? `IPR_SPI_EVT_LSB :
        (gi == 3) ? `IPR_SPI_FLT_LSB :
        (gi == 2) ? `IPR_CAP5_LSB :
        (gi == 1) ? `IPR_CAP4_LSB : `IPR_CAP3_LSB;
      localparam integer ON_CAP = (gi < 3) ? 1 : 0;
      wire sel;
      wire [2:0] val;
      assign sel = do_write & cur_wstrb[LSB / 8] &
        ((ON_CAP == 1) ? hit_cap : hit_spi);
      ipr_field u_field (
        .clk(CLK_SYS),
        .srst(SRST),
        .wr_en(sel),
        .wr_data(cur_wdata[LSB + 2:LSB]),
        .value(val)
      );
      assign field_val[gi * 3 + 2:gi * 3] = val;
    end
  endgenerate

  // Unimplemented bits read as zero.
  assign spi_word = {9'h000, field_val[14:12], 1'b0, field_val[11:9]};
  assign cap_word = {1'b0, field_val[8:6], 1'b0, field_val[5:3],
    1'b0, field_val[2:0], 4'h0};

  always @* begin
    next_rdata = 32'h00000000;
    next_rresp = `IPR_RESP_OKAY;
    case (S_AXI_ARADDR[31:2])
      {26'h0, `IPR_OFF_SPI >> 2}: begin
        next_rdata = {16'h0000, spi_word};
      end
      {26'h0, `IPR_OFF_CAP >> 2}: begin
        next_rdata = {16'h0000, cap_word};
      end
      default: begin
        next_rresp = `IPR_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (SRST) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `IPR_RESP_OKAY;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `IPR_RESP_OKAY;
      SERIAL_PORT_EVENT_PRIORITY <= `IPR_FIELD_RESET;
      SERIAL_PORT_FAULT_PRIORITY <= `IPR_FIELD_RESET;
      CAPTURE_CH5_PRIORITY <= `IPR_FIELD_RESET;
      CAPTURE_CH4_PRIORITY <= `IPR_FIELD_RESET;
      CAPTURE_CH3_PRIORITY <= `IPR_FIELD_RESET;
    end else begin
      // Output copies lag the field flops by one cycle so every
      // top-level output stays a flop.
      SERIAL_PORT_EVENT_PRIORITY <= field_val[14:12];
      SERIAL_PORT_FAULT_PRIORITY <= field_val[11:9];
      CAPTURE_CH5_PRIORITY <= field_val[8:6];
      CAPTURE_CH4_PRIORITY <= field_val[5:3];
      CAPTURE_CH3_PRIORITY <= field_val[2:0];
      if (S_AXI_AWVALID & S_AXI_AWREADY & ~do_write) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID & S_AXI_WREADY & ~do_write) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (hit_spi | hit_cap) ?
          `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
      end else if (S_AXI_BVALID & S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      S_AXI_AWREADY <= ~S_AXI_AWREADY & ~have_aw & ~S_AXI_BVALID &
        S_AXI_AWVALID;
      S_AXI_WREADY <= ~S_AXI_WREADY & ~have_w & ~S_AXI_BVALID &
        S_AXI_WVALID;
      if (S_AXI_ARVALID & S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= next_rdata;
        S_AXI_RRESP <= next_rresp;
      end else begin
        S_AXI_ARREADY <= ~S_AXI_ARREADY & ~S_AXI_RVALID & S_AXI_ARVALID;
        if (S_AXI_RVALID & S_AXI_RREADY) begin
          S_AXI_RVALID <= 1'b0;
        end
      end
    end
  end

endmodule // ipr_regs

// ===== ipr_regs_bench.sv
/* Bench for the priority register slice over its register bus.
   Assumes the design answers each request within a few cycles. */
`timescale 1ns/1ns
module ipr_regs_bench;
  reg CLK_SYS = 0, SRST = 1;
  reg [31:0] S_AXI_AWADDR = 0, S_AXI_WDATA = 0, S_AXI_ARADDR = 0;
  reg [3:0] S_AXI_WSTRB = 4'hf;
  reg S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  reg S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  wire S_AXI_RVALID;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  wire [2:0] SERIAL_PORT_EVENT_PRIORITY, SERIAL_PORT_FAULT_PRIORITY;
  wire [2:0] CAPTURE_CH5_PRIORITY, CAPTURE_CH4_PRIORITY, CAPTURE_CH3_PRIORITY;
  wire [14:0] f = {SERIAL_PORT_EVENT_PRIORITY, SERIAL_PORT_FAULT_PRIORITY,
    CAPTURE_CH5_PRIORITY, CAPTURE_CH4_PRIORITY, CAPTURE_CH3_PRIORITY};
  int n_mismatch = 0, n_compared = 0;
  ipr_regs u_ipr_regs (.*);
  always #50 CLK_SYS = ~CLK_SYS;
  task chk(input string what, input [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [31:0] a, d, input [1:0] er);
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
      if (S_AXI_BVALID) begin
        S_AXI_BREADY <= 0;
        chk("bresp", {30'h0, S_AXI_BRESP}, {30'h0, er});
      end
    end while (S_AXI_AWVALID || S_AXI_WVALID || S_AXI_BREADY);
  endtask
  task rd(input [31:0] a, e, input [1:0] er);
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY <= 1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
      if (S_AXI_RVALID) begin
        S_AXI_RREADY <= 0;
        chk("rdata", S_AXI_RDATA, e);
        chk("rresp", {30'h0, S_AXI_RRESP}, {30'h0, er});
      end
    end while (S_AXI_ARVALID || S_AXI_RREADY);
  endtask
  task complete_run;
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // The watchdog span is about twenty times what the sequence needs.
  initial begin
    repeat (2000) @(posedge CLK_SYS);
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge CLK_SYS);
    SRST <= 0;
    @(posedge CLK_SYS);
    chk("fields", {17'h0, f}, 32'h4924);
    rd(32'h0, 32'h44, 2'h0);
    rd(32'h4, 32'h4440, 2'h0);
    wr(32'h0, 32'hffffffff, 2'h0);
    wr(32'h4, 32'hffffffff, 2'h0);
    rd(32'h0, 32'h77, 2'h0);
    rd(32'h4, 32'h7770, 2'h0);
    chk("fields", {17'h0, f}, 32'h7fff);
    wr(32'h0, 32'hffffff98, 2'h0);
    wr(32'h4, 32'hffffabdf, 2'h0);
    rd(32'h0, 32'h10, 2'h0);
    rd(32'h4, 32'h2350, 2'h0);
    chk("fields", {17'h0, f}, 32'h109d);
    // An unmapped write must leave every field alone.
    wr(32'h8, 32'h7, 2'h2);
    rd(32'h8, 32'h0, 2'h2);
    chk("fields", {17'h0, f}, 32'h109d);
    // Only the upper lane is enabled, so channel 3 must keep its value.
    S_AXI_WSTRB <= 4'h2;
    wr(32'h4, 32'h00000000, 2'h0);
    S_AXI_WSTRB <= 4'hf;
    rd(32'h4, 32'h0050, 2'h0);
    chk("fields", {17'h0, f}, 32'h1005);
    complete_run;
  end
endmodule // ipr_regs_bench

// ===== ipr_regs_sva.sv
/* Checker of the priority register slice.
   Assumes a bind to ipr_regs and full-word writes offered together. */
`timescale 1ns/1ns
module ipr_regs_sva (
  // Clock, reset and bus.
  input wire CLK_SYS, SRST,
  input wire [31:0] S_AXI_AWADDR, S_AXI_WDATA, S_AXI_RDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
  input wire S_AXI_RVALID, S_AXI_BVALID,
  // Priority fields.
  input wire [2:0] SERIAL_PORT_EVENT_PRIORITY, SERIAL_PORT_FAULT_PRIORITY,
  input wire [2:0] CAPTURE_CH5_PRIORITY, CAPTURE_CH4_PRIORITY,
  input wire [2:0] CAPTURE_CH3_PRIORITY
);
  wire [14:0] f = {SERIAL_PORT_EVENT_PRIORITY, SERIAL_PORT_FAULT_PRIORITY,
    CAPTURE_CH5_PRIORITY, CAPTURE_CH4_PRIORITY, CAPTURE_CH3_PRIORITY};
  wire tk = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  rst_value_a: assert property (disable iff (1'b0)
    $fell(SRST) |-> f == 15'h4924) else $error("fields not 100 after reset");
  spi_write_a: assert property (tk && S_AXI_AWADDR == 32'h0
    && S_AXI_WSTRB[0] |-> ##2 {SERIAL_PORT_EVENT_PRIORITY, 1'b0,
    SERIAL_PORT_FAULT_PRIORITY} == ($past(S_AXI_WDATA[6:0], 2) & 7'h77))
    else $error("serial port fields not written");
  cap_write_a: assert property (tk && S_AXI_AWADDR == 32'h4
    && S_AXI_WSTRB[1:0] == 2'h3 |-> ##2 {CAPTURE_CH5_PRIORITY, 1'b0,
    CAPTURE_CH4_PRIORITY, 1'b0, CAPTURE_CH3_PRIORITY}
    == ($past(S_AXI_WDATA[14:4], 2) & 11'h777))
    else $error("capture fields not written");
  rd_zero_a: assert property (S_AXI_RVALID |->
    (S_AXI_RDATA & 32'hffff8888) == 32'h0) else $error("unused bits set");
  out_change_a: assert property ($changed(f) |->
    $past(S_AXI_BVALID)) else $error("field moved without a write");
  cover property (tk && S_AXI_AWADDR == 32'h0);
  cover property (tk && S_AXI_AWADDR == 32'h4);
  cover property ($changed(f));
endmodule // ipr_regs_sva
bind ipr_regs ipr_regs_sva u_ipr_regs_sva (.*);
